// ### clock_startup_reset_control_test.sv
`timescale 1ns/1ps
module clock_startup_reset_control_test;
  import cssrc_pkg::*;
  localparam int OSC_STARTUP_TIMER = 8;
  logic        clk_i = 0, rst_i = 1, por_i = 1, osc_en = 0;
  logic        clock_fail_monitor_en_i = 0, wb_we_i = 0;
  logic        wb_cyc_i = 0, wb_stb_i = 0;
  logic [2:0]  initial_osc_select_i = SRC_FRC8, s;
  logic [15:0] dly = 16'h0000;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, v, w;
  logic        wb_ack_o, cpu_run_o, trap_handler_o, pll_en_o, irq_o;
  logic        osc_running_i, pll_lock_i, clk_out_o, fast_div_en_o;
  logic        low_power_rc_osc_en_o;
  logic [2:0]  active_src_o;
  int          error_cnt = 0, checked = 0, seed = 32'h0f306343, k;
  int          mdl[2] = '{0, 0};

  cssrc_ctrl #(.OST_CYCLES(OSC_STARTUP_TIMER)) cssrc_ctrl_i (.clk_i, .rst_i, .por_i,
    .initial_osc_select_i, .clock_fail_monitor_en_i, .osc_running_i,
    .pll_lock_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .cpu_run_o, .trap_handler_o,
    .active_src_o, .pll_en_o, .fast_div_en_o, .clk_out_o,
    .low_power_rc_osc_en_o, .irq_o);
  cssrc_osc_model cssrc_osc_model_i (.clk_i, .en_i(osc_en),
    .run_dly_i(dly), .osc_running_o(osc_running_i),
    .pll_lock_o(pll_lock_i));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic [7:0] a, input logic we,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i <= we;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      complete_run();
    end
  endtask

  task automatic do_reset(input logic p, input logic [2:0] src,
                          input logic m, input logic o);
    @(posedge clk_i);
    rst_i <= 1'b1;
    por_i <= p;
    initial_osc_select_i <= src;
    clock_fail_monitor_en_i <= m;
    osc_en <= o;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    if (p) mdl = '{0, 0};
  endtask

  task automatic wait_hi(ref logic sig, input int lim, output int n);
    n = 0;
    while (sig !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) begin
      error_cnt++;
      complete_run();
    end
  endtask

  initial begin
    // reset value of control follows the start source; pll where allowed
    for (int i = 0; i < 8; i++) begin
      s = 3'(i);
      do_reset(1'b1, s, 1'b0, 1'b1);
      wb(ADDR_OSC_CTRL, 1'b0, 32'h0);
      check({29'h0, rd[14:12]}, {29'h0, s});
      check({31'h0, pll_en_o}, {31'h0, i == 1 || i == 3 || i == 5});
      wb(ADDR_CAUSE, 1'b0, 32'h0);
      check({31'h0, rd[CAUSE_POR_BIT]}, 32'h1);
    end
    $display("test reset_sources done");
    // crystal idle at release: cpu held until qualified clock
    dly <= 16'd40;
    for (int i = 0; i < 2; i++) begin
      s = i ? SRC_XTAL_PLL : SRC_XTAL;
      do_reset(1'b1, s, 1'b0, 1'b0);
      repeat (60) @(posedge clk_i);
      check({31'h0, cpu_run_o}, 32'h0);
      check({29'h0, active_src_o}, {29'h0, s});
      osc_en <= 1'b1;
      wait_hi(cpu_run_o, 300, k);
      check({31'h0, k > (i ? 56 : 40 + OSC_STARTUP_TIMER)}, 32'h1);
    end
    $display("test startup_stall done");
    // monitor finds no clock: fallback, trap, irq, reselect
    do_reset(1'b1, SRC_XTAL, 1'b1, 1'b0);
    wait_hi(trap_handler_o, 400, k);
    repeat (2) @(posedge clk_i);
    check({29'h0, active_src_o}, {29'h0, SRC_FRC8});
    check({31'h0, irq_o}, 32'h0);
    wb(ADDR_OSC_CTRL, 1'b0, 32'h0);
    check({31'h0, rd[OSC_CF_BIT]}, 32'h1);
    wb(ADDR_IRQ_MASK, 1'b1, 32'h1);
    @(posedge clk_i);
    check({31'h0, irq_o}, 32'h1);
    wb(ADDR_IRQ_STAT, 1'b1, 32'h3);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0);
    osc_en <= 1'b1;
    wb(ADDR_OSC_CTRL, 1'b1, {21'h0, SRC_XTAL, 8'h01});
    k = 0;
    while (active_src_o !== SRC_XTAL && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    check({29'h0, active_src_o}, {29'h0, SRC_XTAL});
    $display("test clock_fail done");
    // low power rc tick spacing
    wait_hi(low_power_rc_osc_en_o, 7000, k);
    @(posedge clk_i);
    wait_hi(low_power_rc_osc_en_o, 7000, k);
    check(32'(k), 32'(LOW_POWER_RC_OSC_DIV - 1));
    $display("test low_power_rc_osc_tick done");
    // fast divider spacing and external clock out toggle
    do_reset(1'b1, SRC_EXT, 1'b0, 1'b1);
    v = {29'h0, 3'($random(seed))};
    wb(ADDR_DIV, 1'b1, v);
    wait_hi(fast_div_en_o, 400, k);
    @(posedge clk_i);
    wait_hi(fast_div_en_o, 400, k);
    check(32'(k), v);
    wb(ADDR_OSC_CTRL, 1'b1, {21'h0, SRC_EXT, 8'h02});
    repeat (3) @(posedge clk_i);
    w = {31'h0, clk_out_o};
    @(posedge clk_i);
    check({31'h0, clk_out_o}, {31'h0, ~w[0]});
    $display("test divider_clkout done");
    // power-on-only registers against system reset
    v = $random(seed);
    w = $random(seed);
    wb(ADDR_RTC_CAL, 1'b1, v);
    mdl[0] = int'(v[15:0]);
    wb(ADDR_NVM_CTRL, 1'b1, w);
    mdl[1] = int'(w[15:0]);
    wb(ADDR_IRQ_MASK, 1'b1, 32'h3);
    wb(ADDR_CAUSE, 1'b1, 32'h7);
    for (int p = 0; p < 2; p++) begin
      do_reset(p[0], SRC_FRC8, 1'b0, 1'b1);
      wb(ADDR_RTC_CAL, 1'b0, 32'h0);
      check(rd, 32'(mdl[0]));
      wb(ADDR_NVM_CTRL, 1'b0, 32'h0);
      check(rd, 32'(mdl[1]));
      wb(ADDR_IRQ_MASK, 1'b0, 32'h0);
      check(rd, 32'h0);
      wb(ADDR_CAUSE, 1'b0, 32'h0);
      check({31'h0, rd[CAUSE_POR_BIT]}, 32'(p));
    end
    wb(8'h20, 1'b1, v);
    wb(8'h20, 1'b0, 32'h0);
    check(rd, 32'h0);
    $display("test por_only done");
    complete_run();
  end
endmodule // clock_startup_reset_control_test

// ### cssrc_ctrl.sv
`timescale 1ns/1ps
module cssrc_ctrl
  import cssrc_pkg::*;
#(
  parameter int OST_CYCLES = OST_CYCLES_NOM
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        por_i,
  input  wire logic [2:0]  initial_osc_select_i,
  input  wire logic        clock_fail_monitor_en_i,
  input  wire logic        osc_running_i,
  input  wire logic        pll_lock_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             cpu_run_o,
  output logic             trap_handler_o,
  output logic      [2:0]  active_src_o,
  output logic             pll_en_o,
  output logic             fast_div_en_o,
  output logic             clk_out_o,
  output logic             low_power_rc_osc_en_o,
  output logic             irq_o
);
  typedef enum logic [1:0] {ST_WAIT, ST_CHECK, ST_RUN} cssrc_state_t;

  function automatic logic uses_pll(input logic [2:0] s);
    return s == SRC_FRC8_PLL || s == SRC_XTAL_PLL || s == SRC_EXT_PLL;
  endfunction
  function automatic logic uses_xtal(input logic [2:0] s);
    return s == SRC_XTAL || s == SRC_XTAL_PLL;
  endfunction
  function automatic logic is_ext(input logic [2:0] s);
    return s == SRC_EXT || s == SRC_EXT_PLL;
  endfunction

  // pin synchronisers, three stages, change once stages two and three agree
  logic [2:0] run_sync_reg, lock_sync_reg;
  logic       run_q_reg, lock_q_reg;
  always_ff @(posedge clk_i) begin
    run_sync_reg  <= {run_sync_reg[1:0], osc_running_i};
    lock_sync_reg <= {lock_sync_reg[1:0], pll_lock_i};
    if (run_sync_reg[1] == run_sync_reg[2]) begin
      run_q_reg <= run_sync_reg[2];
    end
    if (lock_sync_reg[1] == lock_sync_reg[2]) begin
      lock_q_reg <= lock_sync_reg[2];
    end
  end

  cssrc_state_t state_reg, state_next;
  logic [2:0]  cur_reg, cur_next, new_reg, new_next;
  logic        sw_reg, sw_next, cf_reg, cf_next, cko_reg, cko_next;
  logic [15:0] ost_reg, ost_next;
  logic [15:0] cause_reg, cause_next;
  logic [15:0] rtc_config_calib_reg, rtc_next;
  logic [15:0] nvm_control_reg, nvm_next;
  logic [DIV_W-1:0] div_reg, div_next, dcnt_reg, dcnt_next;
  logic [IRQ_W-1:0] stat_reg, stat_next, mask_reg, mask_next;
  logic [12:0] low_power_rc_osc_reg, low_power_rc_osc_next;
  logic        cko_tgl_reg, cko_tgl_next, trap_reg, trap_next;
  logic        run_reg, run_next, low_power_rc_osc_en_reg, low_power_rc_osc_en_next;
  logic        ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic        wr_acc, pll_ok, xtal_ok, clk_valid, fail_ev, valid_ev;
  logic [15:0] osc_view;

  assign wr_acc   = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && wb_sel_i[0];
  assign xtal_ok  = !uses_xtal(cur_reg) || ost_reg >= 16'(OST_CYCLES);
  assign pll_ok   = !uses_pll(cur_reg) || lock_q_reg;
  assign clk_valid = run_q_reg && xtal_ok && pll_ok;
  assign osc_view = {1'b0, cur_reg, 1'b0, new_reg, 2'b00, lock_q_reg, 1'b0,
                     cf_reg, 1'b0, cko_reg, sw_reg};

  always_comb begin
    state_next   = state_reg;
    cur_next     = cur_reg;
    new_next     = new_reg;
    sw_next      = sw_reg;
    cf_next      = cf_reg;
    cko_next     = cko_reg;
    ost_next     = ost_reg;
    cause_next   = cause_reg;
    rtc_next     = rtc_config_calib_reg;
    nvm_next     = nvm_control_reg;
    div_next     = div_reg;
    mask_next    = mask_reg;
    trap_next    = 1'b0;
    run_next     = run_reg;
    low_power_rc_osc_en_next = low_power_rc_osc_en_reg;
    fail_ev      = 1'b0;
    valid_ev     = 1'b0;
    // start-up timer counts on a running crystal, whatever the reset state
    if (!run_q_reg) begin
      ost_next = '0;
    end else if (ost_reg != 16'hffff) begin
      ost_next = ost_reg + 16'h0001;
    end
    unique case (state_reg)
      ST_WAIT: begin
        if (clock_fail_monitor_en_i) begin
          state_next = ST_CHECK;
        end else if (clk_valid) begin
          state_next = ST_RUN;
          valid_ev   = 1'b1;
        end
      end
      ST_CHECK: begin
        state_next = ST_RUN;
        if (clk_valid) begin
          valid_ev = 1'b1;
        end else begin
          cur_next   = SRC_FRC8;
          cf_next    = 1'b1;
          trap_next  = 1'b1;
          fail_ev    = 1'b1;
        end
      end
      ST_RUN: begin
        run_next = clk_valid || cur_reg == SRC_FRC8;
      end
    endcase
    if (sw_reg && state_reg == ST_RUN) begin
      cur_next = new_reg;
      sw_next  = 1'b0;
      cf_next  = 1'b0;
    end
    if (wr_acc) begin
      unique case (wb_adr_i)
        ADDR_OSC_CTRL: begin
          if (wb_sel_i[1]) begin
            new_next = wb_dat_i[10:8];
          end
          cko_next = wb_dat_i[OSC_CKO_BIT];
          if (wb_dat_i[OSC_SW_BIT]) begin
            sw_next = 1'b1;
          end
        end
        ADDR_CAUSE:    cause_next = cause_reg & ~wb_dat_i[15:0];
        ADDR_RTC_CAL:  rtc_next = wb_dat_i[15:0];
        ADDR_NVM_CTRL: nvm_next = wb_dat_i[15:0];
        ADDR_DIV:      div_next = wb_dat_i[DIV_W-1:0];
        ADDR_IRQ_MASK: mask_next = wb_dat_i[IRQ_W-1:0];
        default: ;
      endcase
    end
    // fail event wins over a same-cycle clear of the cause bit
    cause_next[CAUSE_CF_BIT] = cause_next[CAUSE_CF_BIT] | fail_ev;
    stat_next = stat_reg;
    if (wr_acc && wb_adr_i == ADDR_IRQ_STAT) begin
      stat_next = stat_reg & ~wb_dat_i[IRQ_W-1:0];
    end
    stat_next[IRQ_FAIL_BIT]  = stat_next[IRQ_FAIL_BIT] | fail_ev;
    stat_next[IRQ_VALID_BIT] = stat_next[IRQ_VALID_BIT] | valid_ev;
    // low power rc divider, free of every other source
    low_power_rc_osc_next    = (low_power_rc_osc_reg == 13'(LOW_POWER_RC_OSC_DIV - 1)) ? '0 : low_power_rc_osc_reg + 13'h1;
    low_power_rc_osc_en_next = low_power_rc_osc_reg == 13'(LOW_POWER_RC_OSC_DIV - 1);
    // fast oscillator divider enable
    dcnt_next    = (dcnt_reg >= div_reg) ? '0 : dcnt_reg + 1'b1;
    // clock out: system clock / 2 only in external modes
    cko_tgl_next = (is_ext(cur_reg) && cko_reg) ? ~cko_tgl_reg : 1'b0;
    ack_next     = wb_cyc_i && wb_stb_i && !ack_reg;
    rdat_next    = '0;
    unique case (wb_adr_i)
      ADDR_OSC_CTRL: rdat_next[15:0] = osc_view;
      ADDR_CAUSE:    rdat_next[15:0] = cause_reg;
      ADDR_RTC_CAL:  rdat_next[15:0] = rtc_config_calib_reg;
      ADDR_NVM_CTRL: rdat_next[15:0] = nvm_control_reg;
      ADDR_DIV:      rdat_next[DIV_W-1:0] = div_reg;
      ADDR_IRQ_STAT: rdat_next[IRQ_W-1:0] = stat_reg;
      ADDR_IRQ_MASK: rdat_next[IRQ_W-1:0] = mask_reg;
      ADDR_STATUS:   rdat_next[3:0] = {run_reg, clk_valid, state_reg};
      default:       rdat_next = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= ST_WAIT;
      new_reg     <= SRC_FRC8;
      sw_reg      <= 1'b0;
      cf_reg      <= 1'b0;
      cko_reg     <= 1'b0;
      div_reg     <= '0;
      mask_reg    <= '0;
      stat_reg    <= '0;
      trap_reg    <= 1'b0;
      run_reg     <= 1'b0;
      ack_reg     <= 1'b0;
      rdat_reg    <= '0;
      dcnt_reg    <= '0;
      cko_tgl_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      new_reg     <= new_next;
      sw_reg      <= sw_next;
      cf_reg      <= cf_next;
      cko_reg     <= cko_next;
      div_reg     <= div_next;
      mask_reg    <= mask_next;
      stat_reg    <= stat_next;
      trap_reg    <= trap_next;
      run_reg     <= run_next;
      ack_reg     <= ack_next;
      rdat_reg    <= rdat_next;
      dcnt_reg    <= dcnt_next;
      cko_tgl_reg <= cko_tgl_next;
    end
  end

  // reset-type dependent registers: power-on wins over system reset
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      cause_reg            <= 16'h0001 << CAUSE_POR_BIT;
      rtc_config_calib_reg <= RST_ZERO;
      nvm_control_reg      <= RST_ZERO;
      cur_reg              <= initial_osc_select_i;
    end else if (rst_i) begin
      cause_reg <= cause_reg | (16'h0001 << CAUSE_SYS_BIT);
      cur_reg   <= initial_osc_select_i;
    end else begin
      cause_reg            <= cause_next;
      rtc_config_calib_reg <= rtc_next;
      nvm_control_reg      <= nvm_next;
      cur_reg              <= cur_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      low_power_rc_osc_reg    <= '0;
      low_power_rc_osc_en_reg <= 1'b0;
    end else begin
      low_power_rc_osc_reg    <= low_power_rc_osc_next;
      low_power_rc_osc_en_reg <= low_power_rc_osc_en_next;
    end
    ost_reg <= ost_next;
  end

  assign wb_dat_o              = rdat_reg;
  assign wb_ack_o              = ack_reg;
  assign cpu_run_o             = run_reg;
  assign trap_handler_o        = trap_reg;
  assign active_src_o          = cur_reg;
  assign pll_en_o              = uses_pll(cur_reg);
  assign fast_div_en_o         = dcnt_reg == '0;
  assign clk_out_o             = cko_tgl_reg;
  assign low_power_rc_osc_en_o = low_power_rc_osc_en_reg;
  assign irq_o                 = |(stat_reg & mask_reg);

  stall_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cpu_run_o |-> $past(clk_valid) || $past(cur_reg) == SRC_FRC8)
    else $error("cpu runs without valid clock");
  mon_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_WAIT && clock_fail_monitor_en_i |=> state_reg == ST_CHECK)
    else $error("monitor did not start");
  fallback_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_CHECK && !clk_valid |=> cur_reg == SRC_FRC8 && cf_reg)
    else $error("no fallback to fast osc");
  trap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_CHECK && !clk_valid |=> trap_handler_o)
    else $error("no trap after fallback");
  pll_gate_a: assert property (@(posedge clk_i)
    pll_en_o |-> uses_pll(active_src_o))
    else $error("pll on for non pll source");
  xtal_ost_a: assert property (@(posedge clk_i) disable iff (rst_i)
    uses_xtal(cur_reg) && ost_reg < 16'(OST_CYCLES) |-> !clk_valid)
    else $error("crystal valid before timer");
  por_only_a: assert property (@(posedge clk_i)
    rst_i && !por_i |=> $stable(nvm_control_reg))
    else $error("nvm reg changed on system reset");
  cause_por_a: assert property (@(posedge clk_i)
    por_i |=> cause_reg[CAUSE_POR_BIT])
    else $error("cause lacks power-on");
  irq_lvl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == |(stat_reg & mask_reg))
    else $error("irq level wrong");
  fail_cov: cover property (@(posedge clk_i) fail_ev);
  valid_cov: cover property (@(posedge clk_i) valid_ev);
  switch_cov: cover property (@(posedge clk_i) sw_reg && state_reg == ST_RUN);
endmodule // cssrc_ctrl

// ### cssrc_osc_model.sv
`timescale 1ns/1ps
// crystal with start-up delay and pll lock behind it
module cssrc_osc_model (
  input  wire logic        clk_i,
  input  wire logic        en_i,
  input  wire logic [15:0] run_dly_i,
  output logic             osc_running_o,
  output logic             pll_lock_o
);
  int cnt;
  initial begin
    cnt = 0;
    osc_running_o = 1'b0;
    pll_lock_o = 1'b0;
  end
  // start-up counts on regardless of device reset
  always @(posedge clk_i) begin
    cnt <= en_i ? cnt + 1 : 0;
    osc_running_o <= en_i && (cnt >= run_dly_i);
    pll_lock_o <= en_i && (cnt >= run_dly_i + 16);
  end
endmodule // cssrc_osc_model

// ### cssrc_pkg.sv
package cssrc_pkg;
  // wishbone register offsets (byte addresses)
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CAUSE    = 8'h04;
  localparam logic [7:0] ADDR_RTC_CAL  = 8'h08;
  localparam logic [7:0] ADDR_NVM_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_DIV      = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1c;
  // oscillator source codes
  localparam logic [2:0] SRC_FRC8     = 3'h0;
  localparam logic [2:0] SRC_FRC8_PLL = 3'h1;
  localparam logic [2:0] SRC_XTAL     = 3'h2;
  localparam logic [2:0] SRC_XTAL_PLL = 3'h3;
  localparam logic [2:0] SRC_EXT      = 3'h4;
  localparam logic [2:0] SRC_EXT_PLL  = 3'h5;
  localparam logic [2:0] SRC_LOW_POWER_RC_OSC     = 3'h6;
  localparam logic [2:0] SRC_FRC500   = 3'h7;
  // osc_control_reg fields
  localparam int OSC_CUR_LSB  = 12;
  localparam int OSC_NEW_LSB  = 8;
  localparam int OSC_LOCK_BIT = 5;
  localparam int OSC_CF_BIT   = 3;
  localparam int OSC_CKO_BIT  = 1;
  localparam int OSC_SW_BIT   = 0;
  // reset_cause_reg fields
  localparam int CAUSE_POR_BIT = 0;
  localparam int CAUSE_SYS_BIT = 1;
  localparam int CAUSE_CF_BIT  = 2;
  // interrupt status bits
  localparam int IRQ_FAIL_BIT  = 0;
  localparam int IRQ_VALID_BIT = 1;
  localparam int IRQ_W         = 2;
  // divider widths: frc8 /256 -> 31 khz, frc500 /256 -> 2 khz
  localparam int DIV_W = 8;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  // timing
  localparam int CLK_MHZ         = 200;
  localparam int OST_CYCLES_NOM  = 1024;
  localparam int FAIL_WINDOW_NS  = 1000;
  localparam int FAIL_WINDOW_CYC = FAIL_WINDOW_NS * CLK_MHZ / 1000;
  localparam int LOW_POWER_RC_OSC_DIV        = 6452; // 200 mhz / 31 khz
  localparam int PLL_MULT        = 4;    // 8 mhz * 4 = 32 mhz
endpackage
